// ===== rtl/pin_mux_consts.svh
// Offsets, field codes and reset values of the pin function multiplexer
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

`define PM_SEL_BASE       8'h00
`define PM_SEL_COUNT      14
`define PM_DATA_BASE      8'h40
`define PM_DIR_BASE       8'h60
`define PM_PORT_COUNT     6
`define PM_SEL_RESET      8'h00
`define PM_DATA_RESET     8'hFF
`define PM_DIR_RESET      8'hFF
`define PM_PD_SEL1_IDX    7
`define PM_PE_SEL1_IDX    9
`define PM_IN_SEL0_IDX    12
`define PM_IN_SEL1_IDX    13
`define PM_PD_SEL1_MASK   8'h3F
`define PM_PE_SEL1_MASK   8'h03
`define PM_IN_SEL1_MASK   8'h03
`define PM_CODE_ALT1      2'h1
`define PM_CODE_ALT2      2'h2
`define PM_CODE_ALT3      2'h3

`endif

// ===== rtl/pin_mux_pkg.sv
// Types shared by the pin function multiplexer and its surroundings
package pin_mux_pkg;

  typedef struct packed {
    logic       spi_sdo;
    logic       spi_cs_o;
    logic       spi_cs_oe;
    logic       sck_o;
    logic       sck_oe;
    logic       sda_o;
    logic       sda_oe;
    logic       uart_tx;
    logic       compact_timer_out;
    logic       compact_timer_out_inv;
    logic       periodic_timer_out;
    logic       periodic_timer_out_inv;
    logic       standard_timer_out;
    logic       standard_timer_out_inv;
    logic       comparator_out;
  } periph_out_t;

  typedef struct packed {
    logic       spi_chip_select;
    logic       serial_data_in;
    logic       serial_clock_in;
    logic       uart_rx;
    logic       standard_timer_capture_in;
    logic       periodic_timer_capture_in;
    logic       standard_timer_clk_in;
    logic       compact_timer_clk_in;
    logic       periodic_timer_clk_in;
    logic       ext_irq_one;
    logic       ext_irq_zero;
  } periph_in_t;

  typedef struct packed {
    logic [15:0] analog_channel;
    logic        reference_out;
    logic        reference_in;
    logic        comparator_pos_in;
    logic        comparator_neg_in;
    logic        hs_crystal_pin_one;
    logic        hs_crystal_pin_two;
    logic        ls_crystal_pin_one;
    logic        ls_crystal_pin_two;
    logic [3:0]  lcd_common_line;
  } analog_route_t;

endpackage : pin_mux_pkg

// ===== rtl/pin_function_mux.sv
// Pin function multiplexer with Avalon-MM register access
`include "pin_mux_consts.svh"
// How it works
// - Port A selector 0 bits 7:6 at 11 put SPI data out on A3.
// - A1 field at 11 gives SPI chip select; else general I/O.
// - Port A selector 1 code 11 puts UART transmit on A7, receive on A6.
// - Code 11 puts serial clock on A5 and serial data on A4.
// - Fields of A0, A2, B5, E4 are storage only; pins stay general I/O.
// - Code 11 puts compact timer on B3, its inverse on B4, comparator on B0.
// - Code 11 puts periodic timer inverse on B2, true output on B1.
// - Code 11 hands B7, B6, F5, F4 to the crystal oscillators.
// - C3/C2: 10 gives periodic timer outputs, 11 analog channels 3 and 2.
// - C1: comparator, reference out, channel 1; C0: reference in, channel 0.
// - C7/C6: 10 gives standard timer outputs, 11 analog channels 7 and 6.
// - Code 11 connects channels 4, 5 on C4, C5 and 8 to 14 on D0-D6.
// - Unimplemented upper selector bits read back as zero.
// - Code 11 puts compact timer on E3 and its inverse on E2.
// - Code 11 puts standard timer on E1 and its inverse on E0.
// - F3-F0: 10 gives serial and SPI pins, 11 gives LCD commons 3-0.
// - F7 at 11 comparator positive; F6 at 10 negative, 11 channel 15.
// - Input selector 0 bits 7:5 take chip select, data, clock from A or F.
// - Input selector 0 bits 4:0 choose each timer input pin.
// - Input selector 1 bits 1:0 choose external interrupt source pins.
// - Port data and direction latches reset high, so pins start as inputs.
module pin_function_mux #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]          address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  // Peripheral side
  input  wire pin_mux_pkg::periph_out_t   periph_out,
  output pin_mux_pkg::periph_in_t         periph_in,
  output pin_mux_pkg::analog_route_t      analog_route,
  // Pads, port A in bits 7:0 up to port F in bits 47:40
  input  wire logic [47:0]                pad_in,
  output logic      [47:0]                pad_out,
  output logic      [47:0]                pad_oe,
  output logic      [47:0]                pad_analog_en
);

  // Byte addresses up to the direction latches need seven bits
  if (ADDR_W < 7) begin : g_addr_check
    $error("pin_function_mux: ADDR_W must be at least 7");
  end

  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Mask of bits that exist in a selector register
  function automatic logic [7:0] sel_mask(input int idx);
    case (idx)
      `PM_PD_SEL1_IDX: sel_mask = `PM_PD_SEL1_MASK;
      `PM_PE_SEL1_IDX: sel_mask = `PM_PE_SEL1_MASK;
      `PM_IN_SEL1_IDX: sel_mask = `PM_IN_SEL1_MASK;
      default:         sel_mask = 8'hFF;
    endcase
  endfunction : sel_mask

  // Register file and bus handshake
  logic [7:0]  sel_reg  [`PM_SEL_COUNT];
  logic [7:0]  sel_next [`PM_SEL_COUNT];
  logic [7:0]  data_reg  [`PM_PORT_COUNT];
  logic [7:0]  data_next [`PM_PORT_COUNT];
  logic [7:0]  dir_reg  [`PM_PORT_COUNT];
  logic [7:0]  dir_next [`PM_PORT_COUNT];
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0]  byte_addr;

  assign byte_addr   = 8'(address);
  // One wait cycle: the request is taken on the edge after the slave raises its ack
  assign waitrequest = (read | write) & ~ack_reg;
  assign readdata    = rdata_reg;

  always_comb begin
    sel_next   = sel_reg;
    data_next  = data_reg;
    dir_next   = dir_reg;
    ack_next   = (read | write) & ~ack_reg;
    rdata_next = rdata_reg;

    if (read && !ack_reg) begin
      rdata_next = 32'h0000_0000;
      for (int i = 0; i < `PM_SEL_COUNT; i++) begin
        if (byte_addr == 8'(`PM_SEL_BASE + 4 * i)) begin
          rdata_next = {24'h00_0000, sel_reg[i] & sel_mask(i)};
        end
      end
      for (int k = 0; k < `PM_PORT_COUNT; k++) begin
        // An input pin reads the pad, an output pin its own latch
        if (byte_addr == 8'(`PM_DATA_BASE + 4 * k)) begin
          rdata_next = {24'h00_0000, (dir_reg[k] & pad_in[8*k +: 8]) | (~dir_reg[k] & data_reg[k])};
        end
        if (byte_addr == 8'(`PM_DIR_BASE + 4 * k)) begin
          rdata_next = {24'h00_0000, dir_reg[k]};
        end
      end
    end

    if (write && ack_reg && byteenable[0]) begin
      for (int i = 0; i < `PM_SEL_COUNT; i++) begin
        if (byte_addr == 8'(`PM_SEL_BASE + 4 * i)) begin
          sel_next[i] = writedata[7:0] & sel_mask(i);
        end
      end
      for (int k = 0; k < `PM_PORT_COUNT; k++) begin
        if (byte_addr == 8'(`PM_DATA_BASE + 4 * k)) begin
          data_next[k] = writedata[7:0];
        end
        if (byte_addr == 8'(`PM_DIR_BASE + 4 * k)) begin
          dir_next[k] = writedata[7:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      for (int i = 0; i < `PM_SEL_COUNT; i++) begin
        sel_reg[i] <= `PM_SEL_RESET;
      end
      for (int k = 0; k < `PM_PORT_COUNT; k++) begin
        data_reg[k] <= `PM_DATA_RESET;
        dir_reg[k]  <= `PM_DIR_RESET;
      end
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      sel_reg   <= sel_next;
      data_reg  <= data_next;
      dir_reg   <= dir_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Pad routing
  logic [1:0]                 code [48];
  logic [47:0]                own;
  logic [47:0]                own_val;
  logic [47:0]                own_oe;
  logic [47:0]                ana;
  logic [7:0]                 in_sel0;
  logic [7:0]                 in_sel1;
  logic [47:0]                pad_out_next;
  logic [47:0]                pad_oe_next;
  pin_mux_pkg::periph_in_t    pin_next;
  pin_mux_pkg::analog_route_t ar_next;
  pin_mux_pkg::periph_in_t    pin_reg;
  pin_mux_pkg::analog_route_t ar_reg;
  logic [47:0]                pad_out_reg;
  logic [47:0]                pad_oe_reg;
  logic [47:0]                ana_reg;

  assign in_sel0 = sel_reg[`PM_IN_SEL0_IDX];
  assign in_sel1 = sel_reg[`PM_IN_SEL1_IDX];

  always_comb begin
    for (int k = 0; k < `PM_PORT_COUNT; k++) begin
      for (int n = 0; n < 8; n++) begin
        code[8*k+n] = (n < 4) ? sel_reg[2*k][2*n +: 2] : sel_reg[2*k+1][2*(n-4) +: 2];
      end
    end
    own     = 48'h0000_0000_0000;
    own_val = 48'h0000_0000_0000;
    own_oe  = 48'h0000_0000_0000;
    ana     = 48'h0000_0000_0000;
    ar_next = '0;

    // Fields of A0, A2, B5 and E4 are held but never decoded
    if (code[3] == `PM_CODE_ALT3) begin
      own[3] = 1'b1; own_val[3] = periph_out.spi_sdo; own_oe[3] = 1'b1;
    end

    if (code[1] == `PM_CODE_ALT3) begin
      own[1] = 1'b1; own_val[1] = periph_out.spi_cs_o; own_oe[1] = periph_out.spi_cs_oe;
    end

    if (code[7] == `PM_CODE_ALT3) begin
      own[7] = 1'b1; own_val[7] = periph_out.uart_tx; own_oe[7] = 1'b1;
    end

    if (code[6] == `PM_CODE_ALT3) begin
      own[6] = 1'b1;
    end

    if (code[5] == `PM_CODE_ALT3) begin
      own[5] = 1'b1; own_val[5] = periph_out.sck_o; own_oe[5] = periph_out.sck_oe;
    end

    if (code[4] == `PM_CODE_ALT3) begin
      own[4] = 1'b1; own_val[4] = periph_out.sda_o; own_oe[4] = periph_out.sda_oe;
    end

    // Port B timers and comparator, crystal pins on ports B and F
    if (code[11] == `PM_CODE_ALT3) begin
      own[11] = 1'b1; own_val[11] = periph_out.compact_timer_out; own_oe[11] = 1'b1;
    end

    if (code[12] == `PM_CODE_ALT3) begin
      own[12] = 1'b1; own_val[12] = periph_out.compact_timer_out_inv; own_oe[12] = 1'b1;
    end

    if (code[8] == `PM_CODE_ALT3) begin
      own[8] = 1'b1; own_val[8] = periph_out.comparator_out; own_oe[8] = 1'b1;
    end

    if (code[10] == `PM_CODE_ALT3) begin
      own[10] = 1'b1; own_val[10] = periph_out.periodic_timer_out_inv; own_oe[10] = 1'b1;
    end

    if (code[9] == `PM_CODE_ALT3) begin
      own[9] = 1'b1; own_val[9] = periph_out.periodic_timer_out; own_oe[9] = 1'b1;
    end

    ar_next.hs_crystal_pin_two = (code[15] == `PM_CODE_ALT3);
    ar_next.hs_crystal_pin_one = (code[14] == `PM_CODE_ALT3);
    ar_next.ls_crystal_pin_one = (code[45] == `PM_CODE_ALT3);
    ar_next.ls_crystal_pin_two = (code[44] == `PM_CODE_ALT3);

    // Port C timers, comparator and reference
    if (code[19] == `PM_CODE_ALT2) begin
      own[19] = 1'b1; own_val[19] = periph_out.periodic_timer_out_inv; own_oe[19] = 1'b1;
    end

    if (code[18] == `PM_CODE_ALT2) begin
      own[18] = 1'b1; own_val[18] = periph_out.periodic_timer_out; own_oe[18] = 1'b1;
    end

    if (code[23] == `PM_CODE_ALT2) begin
      own[23] = 1'b1; own_val[23] = periph_out.standard_timer_out_inv; own_oe[23] = 1'b1;
    end

    if (code[22] == `PM_CODE_ALT2) begin
      own[22] = 1'b1; own_val[22] = periph_out.standard_timer_out; own_oe[22] = 1'b1;
    end

    if (code[17] == `PM_CODE_ALT1) begin
      own[17] = 1'b1; own_val[17] = periph_out.comparator_out; own_oe[17] = 1'b1;
    end

    ar_next.reference_out = (code[17] == `PM_CODE_ALT2);
    ar_next.reference_in  = (code[16] == `PM_CODE_ALT2);

    // Analog channels 0 to 7 sit on port C in pin order
    for (int n = 0; n < 8; n++) begin
      ar_next.analog_channel[n] = (code[16+n] == `PM_CODE_ALT3);
    end
    for (int n = 0; n < 7; n++) begin
      ar_next.analog_channel[8+n] = (code[24+n] == `PM_CODE_ALT3);
    end

    // Port E timer outputs
    if (code[35] == `PM_CODE_ALT3) begin
      own[35] = 1'b1; own_val[35] = periph_out.compact_timer_out; own_oe[35] = 1'b1;
    end

    if (code[34] == `PM_CODE_ALT3) begin
      own[34] = 1'b1; own_val[34] = periph_out.compact_timer_out_inv; own_oe[34] = 1'b1;
    end

    if (code[33] == `PM_CODE_ALT3) begin
      own[33] = 1'b1; own_val[33] = periph_out.standard_timer_out; own_oe[33] = 1'b1;
    end

    if (code[32] == `PM_CODE_ALT3) begin
      own[32] = 1'b1; own_val[32] = periph_out.standard_timer_out_inv; own_oe[32] = 1'b1;
    end

    // Port F serial pins, display commons and comparator inputs
    if (code[43] == `PM_CODE_ALT2) begin
      own[43] = 1'b1; own_val[43] = periph_out.sck_o; own_oe[43] = periph_out.sck_oe;
    end

    if (code[42] == `PM_CODE_ALT2) begin
      own[42] = 1'b1; own_val[42] = periph_out.sda_o; own_oe[42] = periph_out.sda_oe;
    end

    if (code[41] == `PM_CODE_ALT2) begin
      own[41] = 1'b1; own_val[41] = periph_out.spi_sdo; own_oe[41] = 1'b1;
    end

    if (code[40] == `PM_CODE_ALT2) begin
      own[40] = 1'b1; own_val[40] = periph_out.spi_cs_o; own_oe[40] = periph_out.spi_cs_oe;
    end

    for (int n = 0; n < 4; n++) begin
      ar_next.lcd_common_line[n] = (code[40+n] == `PM_CODE_ALT3);
    end

    ar_next.comparator_pos_in     = (code[47] == `PM_CODE_ALT3);
    ar_next.comparator_neg_in     = (code[46] == `PM_CODE_ALT2);
    ar_next.analog_channel[15]    = (code[46] == `PM_CODE_ALT3);

    // Analog pads get their digital driver switched off
    ana[15]    = ar_next.hs_crystal_pin_two;
    ana[14]    = ar_next.hs_crystal_pin_one;
    ana[45]    = ar_next.ls_crystal_pin_one;
    ana[44]    = ar_next.ls_crystal_pin_two;
    ana[23:16] = ar_next.analog_channel[7:0];
    ana[17]    = ar_next.analog_channel[1] | ar_next.reference_out;
    ana[16]    = ar_next.analog_channel[0] | ar_next.reference_in;
    ana[30:24] = ar_next.analog_channel[14:8];
    ana[43:40] = ar_next.lcd_common_line;
    ana[47]    = ar_next.comparator_pos_in;
    ana[46]    = ar_next.comparator_neg_in | ar_next.analog_channel[15];

    // Storage-only fields never set own, so those pins stay plain port bits
    for (int p = 0; p < 48; p++) begin
      pad_out_next[p] = own[p] ? own_val[p] : data_reg[p/8][p%8];
      pad_oe_next[p]  = ana[p] ? 1'b0 : (own[p] ? own_oe[p] : ~dir_reg[p/8][p%8]);
    end

    pin_next.spi_chip_select           = in_sel0[7] ? pad_in[40] : pad_in[1];
    pin_next.serial_data_in            = in_sel0[6] ? pad_in[42] : pad_in[4];
    pin_next.serial_clock_in           = in_sel0[5] ? pad_in[43] : pad_in[5];
    pin_next.standard_timer_capture_in = in_sel0[4] ? pad_in[33] : pad_in[22];
    pin_next.periodic_timer_capture_in = in_sel0[3] ? pad_in[9] : pad_in[18];
    pin_next.standard_timer_clk_in     = in_sel0[2] ? pad_in[32] : pad_in[23];
    pin_next.compact_timer_clk_in      = in_sel0[1] ? pad_in[34] : pad_in[12];
    pin_next.periodic_timer_clk_in     = in_sel0[0] ? pad_in[10] : pad_in[19];
    pin_next.ext_irq_one               = in_sel1[1] ? pad_in[7] : pad_in[3];
    pin_next.ext_irq_zero              = in_sel1[0] ? pad_in[6] : pad_in[1];
    // Receive is not gated: a receiver ignores its pin until software enables it
    pin_next.uart_rx                   = pad_in[6];
  end

  // Outputs are registered so pads see no glitches while selectors change
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pad_out_reg <= 48'hFFFF_FFFF_FFFF;
      pad_oe_reg  <= 48'h0000_0000_0000;
      ana_reg     <= 48'h0000_0000_0000;
      pin_reg     <= '0;
      ar_reg      <= '0;
    end else begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg  <= pad_oe_next;
      ana_reg     <= ana;
      pin_reg     <= pin_next;
      ar_reg      <= ar_next;
    end
  end

  assign pad_out       = pad_out_reg;
  assign pad_oe        = pad_oe_reg;
  assign pad_analog_en = ana_reg;
  assign periph_in     = pin_reg;
  assign analog_route  = ar_reg;

endmodule : pin_function_mux

// ===== tb/pin_function_mux_assertions.sv
// Port-level checker for the pin function multiplexer
module pin_function_mux_assertions #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     resetn,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0]        address,
  input wire logic                     read,
  input wire logic                     write,
  input wire logic [31:0]              writedata,
  input wire logic [3:0]               byteenable,
  input wire logic [31:0]              readdata,
  input wire logic                     waitrequest,
  // Peripherals and pads
  input wire pin_mux_pkg::periph_out_t periph_out,
  input wire pin_mux_pkg::periph_in_t  periph_in,
  input wire pin_mux_pkg::analog_route_t analog_route,
  input wire logic [47:0]              pad_in,
  input wire logic [47:0]              pad_out,
  input wire logic [47:0]              pad_oe,
  input wire logic [47:0]              pad_analog_en
);
  logic [3:0] rst_pipe_reg;
  logic [7:0] sh_a0_reg;
  logic [7:0] sh_b0_reg;
  logic [1:0] sh_i1_reg;
  logic       ok;
  logic       wr_ok;
  // Shadows follow completed writes so pad checks need no view into the body
  assign wr_ok = write && !waitrequest && byteenable[0];
  assign ok = rst_pipe_reg[3];
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe_reg <= 4'h0;
      sh_a0_reg <= 8'h00;
      sh_b0_reg <= 8'h00;
      sh_i1_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[2:0], 1'b1};
      if (wr_ok && address == 8'h00) sh_a0_reg <= writedata[7:0];
      if (wr_ok && address == 8'h08) sh_b0_reg <= writedata[7:0];
      if (wr_ok && address == 8'h34) sh_i1_reg <= writedata[1:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!ok);

  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held longer than one cycle");
  chk_read_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0
    && (address != 8'h3C || readdata[7:0] == 8'h00))
    else $error("read data upper or unmapped bits not zero");
  chk_analog_oe: assert property ((pad_analog_en & pad_oe) == 48'h0)
    else $error("analog pad also driven");
  chk_irq_route: assert property (periph_in.ext_irq_one == ($past(sh_i1_reg[1]) ? $past(pad_in[7]) : $past(pad_in[3]))
    && periph_in.ext_irq_zero == ($past(sh_i1_reg[0]) ? $past(pad_in[6]) : $past(pad_in[1])))
    else $error("external interrupt source wrong");
  chk_sdo_pin: assert property (sh_a0_reg[7:6] == 2'h3 |=> pad_oe[3] && pad_out[3] == $past(periph_out.spi_sdo))
    else $error("serial data out not on A3");
  chk_cs_pin: assert property (sh_a0_reg[3:2] == 2'h3 |=> pad_oe[1] == $past(periph_out.spi_cs_oe))
    else $error("chip select enable not on A1");
  chk_ptp_pins: assert property (sh_b0_reg[5:2] == 4'hF |=> pad_oe[10:9] == 2'h3
    && pad_out[10:9] == {$past(periph_out.periodic_timer_out_inv), $past(periph_out.periodic_timer_out)})
    else $error("periodic timer outputs not on B2 B1");
  chk_reset_pads: assert property (disable iff (1'b0) !resetn |-> pad_oe == 48'h0)
    else $error("pad driven during reset");

  cov_read: cover property (read && !waitrequest);
  cov_b_alt: cover property (sh_b0_reg == 8'hFF);
  cov_irq_alt: cover property (sh_i1_reg == 2'h3);
endmodule : pin_function_mux_assertions

bind pin_function_mux pin_function_mux_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .periph_out(periph_out), .periph_in(periph_in), .analog_route(analog_route), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_analog_en(pad_analog_en));

// ===== tb/pm_periph_model.sv
// Behavioural model of the peripherals feeding the multiplexer
module pm_periph_model (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  // Peripheral outputs
  output pin_mux_pkg::periph_out_t periph_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Values move every cycle so a stale pad copy cannot pass
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      periph_out <= '0;
    end else begin
      periph_out <= 15'($urandom);
    end
  end
endmodule : pm_periph_model

// ===== tb/pin_function_mux_tb.sv
// Self-checking bench for the pin function multiplexer
module pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       ref_clk = 1'b0;
  logic                       resetn = 1'b1;
  logic [7:0]                 address = 8'h00;
  logic                       read = 1'b0;
  logic                       write = 1'b0;
  logic [31:0]                writedata = 32'h0;
  logic [3:0]                 byteenable = 4'hF;
  logic [31:0]                readdata;
  logic                       waitrequest;
  pin_mux_pkg::periph_out_t   periph_out;
  pin_mux_pkg::periph_in_t    periph_in;
  pin_mux_pkg::analog_route_t analog_route;
  logic [47:0]                pad_in = 48'h0;
  logic [47:0]                pad_out;
  logic [47:0]                pad_oe;
  logic [47:0]                pad_analog_en;
  int                         bad_count = 0;
  int                         n_compared = 0;
  logic [31:0]                rd;
  pin_mux_pkg::periph_out_t   po;
  logic [47:0]                pi;
  logic [7:0]                 s0;
  logic [7:0]                 s1;

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pad_in <= {16'($urandom), 32'($urandom)};

  pin_function_mux #(.ADDR_W(8)) uut (.ref_clk(ref_clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .periph_out(periph_out), .periph_in(periph_in), .analog_route(analog_route),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_analog_en(pad_analog_en));
  pm_periph_model u_periph (.ref_clk(ref_clk), .resetn(resetn), .periph_out(periph_out));

  function automatic logic [7:0] sel_mask(input int i);
    return (i == 7) ? 8'h3F : ((i == 9 || i == 13) ? 8'h03 : 8'hFF);
  endfunction : sel_mask
  function automatic logic [7:0] exp_b(input logic [1:0] c, input pin_mux_pkg::periph_out_t p);
    return (c == 2'h3) ? {3'b000, p.compact_timer_out_inv, p.compact_timer_out, p.periodic_timer_out_inv,
      p.periodic_timer_out, p.comparator_out} : 8'h00;
  endfunction : exp_b
  function automatic pin_mux_pkg::periph_in_t exp_in(input logic [7:0] a, input logic [1:0] b, input logic [47:0] p);
    return '{p[a[7] ? 40 : 1], p[a[6] ? 42 : 4], p[a[5] ? 43 : 5], p[6], p[a[4] ? 33 : 22], p[a[3] ? 9 : 18],
      p[a[2] ? 32 : 23], p[a[1] ? 34 : 12], p[a[0] ? 10 : 19], p[b[1] ? 7 : 3], p[b[0] ? 6 : 1]};
  endfunction : exp_in

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data, output logic [31:0] q);
    logic ws;
    @(posedge ref_clk);
    address <= addr;
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, data};
    do begin
      @(posedge ref_clk);
      ws = waitrequest;
      q = readdata;
    end while (ws !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    bus(1'b1, addr, data, rd);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
    bus(1'b0, addr, 8'h00, rd);
    check(name, {16'h0, rd}, {40'h0, exp});
  endtask : rd_chk
  task automatic sample();
    @(negedge ref_clk);
    po = periph_out;
    pi = pad_in;
    @(negedge ref_clk);
  endtask : sample
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    // A real falling edge, so every asynchronous reset fires before the first clock
    resetn <= 1'b0;
    void'($urandom(32'h4c04));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check("pad_oe_reset", pad_oe, 48'h0);
    for (int i = 0; i < 14; i++) rd_chk("sel_reset", 8'(4 * i), 8'h00);
    for (int k = 0; k < 6; k++) rd_chk("dir_reset", 8'(8'h60 + 4 * k), 8'hFF);
    $display("test reset done");
    for (int n = 0; n < 28; n++) begin
      logic [7:0] v;
      v = 8'($urandom);
      wr(8'(4 * (n % 14)), v);
      rd_chk("sel_rw", 8'(4 * (n % 14)), v & sel_mask(n % 14));
    end
    wr(8'h3C, 8'hA5);
    rd_chk("unmapped", 8'h3C, 8'h00);
    wr(8'h00, 8'hCC);
    byteenable <= 4'h0;
    wr(8'h00, 8'h11);
    byteenable <= 4'hF;
    rd_chk("lane_off", 8'h00, 8'hCC);
    repeat (4) @(posedge ref_clk);
    $display("test registers done");
    // Latch low and pins as outputs, so any peripheral pad differs from the latch
    wr(8'h44, 8'h00);
    wr(8'h64, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, {4{2'(c)}});
      wr(8'h0C, {4{2'(c)}});
      repeat (2) @(posedge ref_clk);
      sample();
      check("b_out", {40'h0, pad_out[15:8] & 8'h3F}, {40'h0, exp_b(2'(c), po)});
      check("b_oe", {40'h0, pad_oe[15:8]}, {40'h0, (c == 3) ? 8'h3F : 8'hFF});
      check("b_analog", {40'h0, pad_analog_en[15:8]}, {40'h0, (c == 3) ? 8'hC0 : 8'h00});
      check("hs_crystal", {46'h0, analog_route.hs_crystal_pin_one, analog_route.hs_crystal_pin_two},
        {46'h0, {2{c == 3}}});
    end
    $display("test port b done");
    // Ports C to F all at code 10, then all at code 11
    for (int c = 2; c < 4; c++) begin
      for (int r = 4; r < 12; r++) wr(8'(4 * r), {4{2'(c)}});
      repeat (2) @(posedge ref_clk);
      sample();
      check("analog_pads", {16'h0, pad_analog_en[47:16]},
        {16'h0, (c == 3) ? 32'hFF00_7FFF : 32'h4000_0003});
      check("analog_route", {20'h0, analog_route}, {20'h0, (c == 3) ? 28'hFFFF_2FF : 28'h0000_DC0});
      if (c == 2) begin
        check("c_pads", {32'h0, pad_oe[23:16], pad_out[23:16] & 8'hCC}, {32'h0, 8'hCC, po.standard_timer_out_inv,
          po.standard_timer_out, 2'b00, po.periodic_timer_out_inv, po.periodic_timer_out, 2'b00});
        check("f_pads", {40'h0, pad_oe[43:40], pad_out[43:40]}, {40'h0, po.sck_oe, po.sda_oe, 1'b1, po.spi_cs_oe,
          po.sck_o, po.sda_o, po.spi_sdo, po.spi_cs_o});
      end else begin
        check("e_pads", {40'h0, pad_oe[35:32], pad_out[35:32]}, {40'h0, 4'hF, po.compact_timer_out,
          po.compact_timer_out_inv, po.standard_timer_out, po.standard_timer_out_inv});
      end
    end
    $display("test analog pins done");
    for (int n = 0; n < 16; n++) begin
      s0 = (n < 2) ? {8{n[0]}} : 8'($urandom);
      s1 = 8'(n % 4);
      // Input sources chosen before the routed inputs are used
      wr(8'h30, s0);
      wr(8'h34, s1);
      sample();
      check("periph_in", {37'h0, periph_in}, {37'h0, exp_in(s0, s1[1:0], pi)});
    end
    $display("test inputs done");
    print_verdict();
  end
endmodule : pin_function_mux_tb
